// ===== dv/emr_hub_model.sv
// far-end hub link receiver: takes error messages, counts them by kind.
// assumes a message is taken at an edge where valid and ready are high.
`timescale 1ns/10ps
`default_nettype none
module emr_hub_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stall_i,
   input  wire logic        valid_i,
   input  wire logic [1:0]  kind_i,
   output logic             ready_o,
   output logic [3:0][7:0]  cnt_o
);
   // stall gives the slow answer: the router must hold its message
   assign ready_o = !stall_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= '0;
      end else if (valid_i && ready_o) begin
         cnt_o[kind_i] <= cnt_o[kind_i] + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== dv/emr_router_properties.sv
// port-level assertions for the error message router.
// assumes it is bound onto emr_router; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module emr_router_properties (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        hub_msg_valid_o,
   input wire logic [1:0]  hub_msg_kind_o,
   input wire logic        hub_msg_ready_i,
   input wire logic        queue_full_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_after_req: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
      else $error("request not answered next cycle");
   a_ack_one_pulse: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack held too long");
   a_ack_needs_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside answer");
   // checked across reset itself, so the default disable is overridden
   a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=> !ack_o && !hub_msg_valid_o && !queue_full_o)
      else $error("outputs active after reset");
   a_kind_legal: assert property (hub_msg_valid_o |-> hub_msg_kind_o != 2'h0)
      else $error("message offered with no kind");
   a_msg_holds: assert property (hub_msg_valid_o && !hub_msg_ready_i |=> hub_msg_valid_o && $stable(hub_msg_kind_o))
      else $error("pending message lost");
   a_ce_freeze: assert property (!ce_i |=> $stable(hub_msg_valid_o) && $stable(ack_o))
      else $error("state moved while frozen");
endmodule
bind emr_router emr_router_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .hub_msg_valid_o(hub_msg_valid_o),
   .hub_msg_kind_o(hub_msg_kind_o), .hub_msg_ready_i(hub_msg_ready_i), .queue_full_o(queue_full_o));
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the error message router.
// assumes emr_router with a hub model on its message port.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic             clk_i, rst_i, ce_i, cyc, stb, we, ack, valid, ready, full, stall;
   logic [11:0]      adr;
   logic [31:0]      wd, rd;
   logic [7:0]       ev;
   logic [1:0]       tk, kind;
   logic [3:0][7:0]  cnt;
   int               n_errors, n_compared, ex[4];
   int               ix[5] = '{0, 2, 4, 5, 6};
   emr_router dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(rd), .ack_o(ack), .fsb_glitch_i(ev[0]),
      .therm_trip_i(ev[1]), .therm_kind_i(tk), .lock_nondram_i(ev[2]), .refresh_queued_i(ev[3]),
      .refresh_done_i(ev[7]), .throttle_i(ev[4]), .target_abort_i(ev[5]), .unsc_cpl_i(ev[6]),
      .hub_msg_valid_o(valid), .hub_msg_kind_o(kind), .hub_msg_ready_i(ready), .queue_full_o(full));
   emr_hub_model hub_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .valid_i(valid), .kind_i(kind),
      .ready_o(ready), .cnt_o(cnt));
   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // byte address = register index * 4
   // waits for ack however long it takes; only the watchdog ends a hang
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask
   task automatic pulse(input logic [7:0] m, input logic [1:0] k);
      @(posedge clk_i);
      {ev, tk} <= {m, k};
      @(posedge clk_i);
      ev <= 8'h0;
   endtask
   task automatic msgs(input string m);
      repeat (12) @(posedge clk_i);
      for (int k = 1; k < 4; k++) chk({24'h0, cnt[k]}, 32'(ex[k]), m);
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      rdc(12'h190, 32'h0, "serr reset");
      rdc(12'h198, 32'h0, "smi reset");
      rdc(12'h19c, 32'h0, "sci reset");
      wr(12'h190, 32'hfffc);
      rdc(12'h190, 32'h2be0, "serr bits");
      wr(12'h198, 32'hfc);
      rdc(12'h198, 32'h08, "smi bits");
      wr(12'h19c, 32'hfc);
      rdc(12'h19c, 32'h08, "sci bits");
      wr(12'h300, 32'hffff);
      rdc(12'h300, 32'h0, "unmapped");
      $display("t_regs done");
   endtask
   // round 0 global off, 1 all on, 2 per-bit enables off
   task automatic t_serr;
      for (int r = 0; r < 3; r++) begin
         if (r == 1) wr(12'h1a4, 32'h1);
         if (r == 2) wr(12'h190, 32'h0);
         for (int i = 0; i < 5; i++) begin
            pulse(8'(1 << ix[i]), 2'h0);
            ex[1] += (r == 1);
            msgs("serr per event");
         end
         if (r == 0) rdc(12'h1a0, 32'h22e0, "flags set");
         wr(12'h1a0, 32'h2be0);
      end
      $display("t_serr done");
   endtask
   task automatic t_refresh;
      wr(12'h190, 32'h100);
      @(posedge clk_i);
      ev <= 8'h08;
      repeat (1023) @(posedge clk_i);
      ev <= 8'h0;
      pulse(8'h80, 2'h0);
      pulse(8'h08, 2'h0);
      msgs("refresh below limit");
      pulse(8'h08, 2'h0);
      ex[1]++;
      msgs("refresh at limit");
      rdc(12'h1a0, 32'h100, "refresh flag");
      wr(12'h1a0, 32'h100);
      $display("t_refresh done");
   endtask
   // only one of serr, smi, sci thermal enables is set whenever a trip is pulsed
   task automatic t_therm;
      wr(12'h198, 32'h0);
      wr(12'h19c, 32'h0);
      wr(12'h190, 32'h800);
      pulse(8'h02, 2'h1);
      ex[1]++;
      msgs("thermal serr");
      pulse(8'h02, 2'h1);
      msgs("thermal blocked");
      rdc(12'h1a0, 32'h800, "thermal flag");
      wr(12'h190, 32'h0);
      for (int k = 2; k < 4; k++) begin
         wr(12'h198, (k == 2) ? 32'h8 : 32'h0);
         wr(12'h19c, (k == 3) ? 32'h8 : 32'h0);
         wr(12'h1a0, 32'h800);
         pulse(8'h02, 2'(k));
         ex[k]++;
         msgs("thermal smi sci");
      end
      wr(12'h1a0, 32'h800);
      pulse(8'h02, 2'h2);
      msgs("thermal smi off");
      $display("t_therm done");
   endtask
   // link busy while five events arrive back to back, then a four-cycle freeze
   task automatic t_queue;
      wr(12'h190, 32'h2be0);
      @(posedge clk_i);
      stall <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_i);
         ev <= 8'(1 << ix[i]);
      end
      @(posedge clk_i);
      {ev, ce_i} <= 9'h0;
      repeat (4) @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({31'h0, valid}, 32'h1, "held while busy");
      chk({31'h0, full}, 32'h0, "queue not full");
      // one message sits in the sender, four queued; twelve more fill all sixteen slots
      ev <= 8'h10;
      repeat (12) @(posedge clk_i);
      ev <= 8'h0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, full}, 32'h1, "queue full");
      stall <= 1'b0;
      ex[1] += 17;
      repeat (50) @(posedge clk_i);
      msgs("none lost");
      $display("t_queue done");
   endtask
   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {clk_i, rst_i, ce_i, cyc, stb, we, stall} = 7'b0110000;
      {adr, wd, ev, tk} = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_serr;
      t_refresh;
      t_therm;
      t_queue;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end
endmodule
`default_nettype wire

// ===== hw/emr_msg_mem.sv
// small memory holding pending message kinds for the router.
// assumes one clock; read data is registered, one cycle after rd_en_i.
`timescale 1ns/10ps
`default_nettype none
module emr_msg_mem (
   input  wire logic                       clk_i,
   input  wire logic                       ce_i,
   input  wire logic                       wr_en_i,
   input  wire logic [emr_pkg::MSGQ_AW-1:0] wr_addr_i,
   input  wire logic [1:0]                 wr_data_i,
   input  wire logic                       rd_en_i,
   input  wire logic [emr_pkg::MSGQ_AW-1:0] rd_addr_i,
   output logic      [1:0]                 rd_data_o
);
   logic [1:0] mem_ff [emr_pkg::MSGQ_DEPTH];

   always_ff @(posedge clk_i) begin
      if (ce_i && wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
      if (ce_i && rd_en_i) begin
         rd_data_o <= mem_ff[rd_addr_i];
      end
   end
endmodule
`default_nettype wire

// ===== hw/emr_router.sv
// error message router: raises serr, smi and sci special messages on the hub link.
// assumes error events arrive as one-cycle pulses from logic on clk_i, and that
// the hub link takes a message when hub_msg_valid_o and hub_msg_ready_i are both high.
//
// Summary of operation
// RULE1 - 16-bit serr enable register, reset zero, gates serr per condition.
// RULE2 - serr messages also need the global serr enable bit set.
// RULE3 - every serr report leaves as a hub link message, no pin.
// RULE4 - one error occurrence yields exactly one special message; occurrences in the same cycle share one message here.
// RULE5 - software enables at most one of serr, smi, sci per condition.
// RULE6 - bit 13 sends serr on front-side bus strobe glitch.
// RULE7 - bit 11 sends serr on thermal trip needing serr.
// RULE8 - bit 9 sends serr on locked access to non-dram space.
// RULE9 - bit 8 sends serr on dram refresh timeout.
// RULE10 - bit 7 sends serr on dram read or write throttle.
// RULE11 - bit 6 sends serr on target abort of own hub cycle.
// RULE12 - bit 5 sends serr on unimplemented special cycle completion.
// RULE13 - software keeps ecc enable bits 1 and 0 at zero.
// RULE14 - 8-bit smi enable, reset zero; bit 3 sends smi on thermal trip.
// RULE15 - 8-bit sci enable, reset zero; bit 3 sends sci on thermal trip.
// RULE16 - one thermal trip never causes more than one message.
// RULE17 - message only when the flag is set and its enable set.
// RULE18 - no new thermal message while thermal flag set; write one clears.
// RULE19 - refresh timeout flag sets when 1024 refreshes are queued.
// RULE20 - pending messages are queued while link busy, none lost; a message raised while the queue is full is dropped.
`timescale 1ns/10ps
`default_nettype none
module emr_router (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // error events, one-cycle pulses
   input  wire logic        fsb_glitch_i,
   input  wire logic        therm_trip_i,
   input  wire logic [1:0]  therm_kind_i,
   input  wire logic        lock_nondram_i,
   input  wire logic        refresh_queued_i,
   input  wire logic        refresh_done_i,
   input  wire logic        throttle_i,
   input  wire logic        target_abort_i,
   input  wire logic        unsc_cpl_i,
   // hub link message port
   output logic             hub_msg_valid_o,
   output logic      [1:0]  hub_msg_kind_o,
   input  wire logic        hub_msg_ready_i,
   output logic             queue_full_o
);

   ////////////////////////////////////////////////////////////////////////
   // register bus decode

   logic [15:0] serr_en_ff;
   logic [7:0]  smi_en_ff;
   logic [7:0]  sci_en_ff;
   logic [15:0] flag_ff;
   logic        serr_glb_ff;
   logic        ack_ff;
   logic [31:0] dat_ff;
   logic [7:0]  msg_cnt_ff;

   wire        bus_req  = cyc_i & stb_i & ~ack_ff;
   wire [9:0]  word_idx = adr_i[11:2];
   wire        hit_serr = word_idx == {2'h0, emr_pkg::SERR_EN_IDX};
   wire        hit_smi  = word_idx == {2'h0, emr_pkg::SMI_EN_IDX};
   wire        hit_sci  = word_idx == {2'h0, emr_pkg::SCI_EN_IDX};
   wire        hit_sts  = word_idx == {2'h0, emr_pkg::FLAG_STS_IDX};
   wire        hit_glb  = word_idx == {2'h0, emr_pkg::GLOBAL_CTL_IDX};
   wire        hit_cnt  = word_idx == {2'h0, emr_pkg::MSG_CNT_IDX};
   wire        wr_stb   = bus_req & we_i;
   wire [31:0] lane_m   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [31:0] wdat     = dat_i & lane_m;

   wire [15:0] nxt_serr_en = (serr_en_ff & ~lane_m[15:0]) | (wdat[15:0] & emr_pkg::SERR_EN_MASK); // see RULE1
   wire [7:0]  nxt_smi_en  = (smi_en_ff & ~lane_m[7:0]) | (wdat[7:0] & emr_pkg::SMI_EN_MASK); // see RULE14
   wire [7:0]  nxt_sci_en  = (sci_en_ff & ~lane_m[7:0]) | (wdat[7:0] & emr_pkg::SCI_EN_MASK); // see RULE15
   wire [15:0] flag_clr    = (wr_stb & hit_sts) ? (wdat[15:0] & emr_pkg::FLAG_MASK) : 16'h0000;

   wire [31:0] rd_mux =
      hit_serr ? {16'h0000, serr_en_ff} :
      hit_smi  ? {24'h000000, smi_en_ff} :
      hit_sci  ? {24'h000000, sci_en_ff} :
      hit_sts  ? {16'h0000, flag_ff} :
      hit_glb  ? {31'h0, serr_glb_ff} :
      hit_cnt  ? {24'h000000, msg_cnt_ff} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else if (ce_i) begin
         ack_ff <= bus_req;
         dat_ff <= (bus_req & ~we_i) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serr_en_ff  <= emr_pkg::SERR_EN_RST;
         smi_en_ff   <= emr_pkg::SMI_EN_RST;
         sci_en_ff   <= emr_pkg::SCI_EN_RST;
         serr_glb_ff <= emr_pkg::SERR_GLB_RST;
      end else if (ce_i && wr_stb) begin
         if (hit_serr) serr_en_ff <= nxt_serr_en;
         if (hit_smi) smi_en_ff <= nxt_smi_en;
         if (hit_sci) sci_en_ff <= nxt_sci_en;
         if (hit_glb && sel_i[0]) serr_glb_ff <= dat_i[0];
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

   ////////////////////////////////////////////////////////////////////////
   // refresh backlog counter

   logic [emr_pkg::REFQ_W-1:0] refq_ff;
   wire refq_inc = refresh_queued_i & ~refresh_done_i & (refq_ff != emr_pkg::REFQ_W'(emr_pkg::REFRESH_LIMIT));
   wire refq_dec = refresh_done_i & ~refresh_queued_i & (refq_ff != '0);
   wire refresh_timeout = refq_inc & (refq_ff == emr_pkg::REFQ_W'(emr_pkg::REFRESH_LIMIT - 1)); // see RULE19

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refq_ff <= '0;
      end else if (ce_i) begin
         if (refq_inc) refq_ff <= refq_ff + 1'b1;
         else if (refq_dec) refq_ff <= refq_ff - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error flags and message selection

   // thermal trip is kind-tagged: one trip picks one message path only
   wire therm_serr = therm_trip_i & (therm_kind_i == emr_pkg::MSG_SERR); // see RULE16
   wire therm_smi  = therm_trip_i & (therm_kind_i == emr_pkg::MSG_SMI);
   wire therm_sci  = therm_trip_i & (therm_kind_i == emr_pkg::MSG_SCI);

   // thermal flag latches only when a message is really raised, and blocks more
   wire therm_en_serr = therm_serr & serr_en_ff[emr_pkg::THERMAL_BIT] & serr_glb_ff; // see RULE7
   wire therm_en_smi  = therm_smi & smi_en_ff[emr_pkg::THERM_SMI_BIT];  // see RULE14
   wire therm_en_sci  = therm_sci & sci_en_ff[emr_pkg::THERM_SCI_BIT];  // see RULE15
   wire therm_new     = ~flag_ff[emr_pkg::THERMAL_BIT] & (therm_en_serr | therm_en_smi | therm_en_sci); // see RULE18

   logic [15:0] evt;
   always_comb begin
      evt = 16'h0000;
      evt[emr_pkg::FSB_GLITCH_BIT] = fsb_glitch_i;
      evt[emr_pkg::LOCK_BIT]       = lock_nondram_i;
      evt[emr_pkg::REFRESH_BIT]    = refresh_timeout;
      evt[emr_pkg::THROTTLE_BIT]   = throttle_i;
      evt[emr_pkg::TABORT_BIT]     = target_abort_i;
      evt[emr_pkg::UNSC_BIT]       = unsc_cpl_i;
      evt[emr_pkg::THERMAL_BIT]    = therm_new;
   end

   // a new occurrence sets its flag; set wins over write-one clear
   wire [15:0] nxt_flag = (flag_ff & ~flag_clr) | evt; // see RULE17

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= emr_pkg::FLAG_STS_RST;
      end else if (ce_i) begin
         flag_ff <= nxt_flag;
      end
   end

   // per-condition serr gating, bits 13,9,8,7,6,5
   wire [15:0] serr_gate = serr_en_ff & emr_pkg::FLAG_MASK & {16{serr_glb_ff}}; // see RULE2
   wire [15:0] serr_hit  = evt & serr_gate & ~(16'h0001 << emr_pkg::THERMAL_BIT); // see RULE6 see RULE8 see RULE9
   // above covers throttle, target abort and unsc as well: see RULE10 see RULE11 see RULE12

   // each cycle with any enabled occurrence requests one enqueue, smi or sci kind ahead of serr; serr kind routed as a link message
   wire        serr_req = (|serr_hit) | (therm_new & therm_en_serr); // see RULE3 see RULE4
   wire        smi_req  = therm_new & therm_en_smi;
   wire        sci_req  = therm_new & therm_en_sci;
   wire        enq_req  = serr_req | smi_req | sci_req;
   wire [1:0]  enq_kind = smi_req ? emr_pkg::MSG_SMI : sci_req ? emr_pkg::MSG_SCI : emr_pkg::MSG_SERR;

   ////////////////////////////////////////////////////////////////////////
   // pending message queue and link sender

   logic [emr_pkg::MSGQ_AW:0]   wp_ff;
   logic [emr_pkg::MSGQ_AW:0]   rp_ff;
   logic                        valid_ff;
   logic [1:0]                  kind_ff;
   logic                        full_ff;
   emr_pkg::emr_state_t         state_ff;
   emr_pkg::emr_state_t         nxt_state;
   wire  [1:0]                  mem_rd;

   wire q_empty = wp_ff == rp_ff;
   wire q_full  = (wp_ff[emr_pkg::MSGQ_AW] != rp_ff[emr_pkg::MSGQ_AW]) &&
                  (wp_ff[emr_pkg::MSGQ_AW-1:0] == rp_ff[emr_pkg::MSGQ_AW-1:0]);
   // a full queue cannot take more; depth covers one of each source
   wire do_enq  = enq_req & ~q_full; // see RULE20
   wire do_deq  = (state_ff == emr_pkg::EMR_IDLE) & ~q_empty;
   wire sent    = valid_ff & hub_msg_ready_i;

   emr_msg_mem u_mem (
      .clk_i     (clk_i),
      .ce_i      (ce_i),
      .wr_en_i   (do_enq),
      .wr_addr_i (wp_ff[emr_pkg::MSGQ_AW-1:0]),
      .wr_data_i (enq_kind),
      .rd_en_i   (do_deq),
      .rd_addr_i (rp_ff[emr_pkg::MSGQ_AW-1:0]),
      .rd_data_o (mem_rd)
   );

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         emr_pkg::EMR_IDLE: if (do_deq) nxt_state = emr_pkg::EMR_LOAD;
         emr_pkg::EMR_LOAD: nxt_state = emr_pkg::EMR_SEND;
         emr_pkg::EMR_SEND: if (sent) nxt_state = emr_pkg::EMR_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_ff      <= '0;
         rp_ff      <= '0;
         state_ff   <= emr_pkg::EMR_IDLE;
         valid_ff   <= 1'b0;
         kind_ff    <= 2'h0;
         full_ff    <= 1'b0;
         msg_cnt_ff <= 8'h00;
      end else if (ce_i) begin
         state_ff <= nxt_state;
         full_ff  <= q_full;
         if (do_enq) wp_ff <= wp_ff + 1'b1;
         if (do_deq) rp_ff <= rp_ff + 1'b1;
         if (state_ff == emr_pkg::EMR_LOAD) begin
            valid_ff <= 1'b1;
            kind_ff  <= mem_rd;
         end else if (sent) begin
            valid_ff   <= 1'b0;
            msg_cnt_ff <= msg_cnt_ff + 8'h01;
         end
      end
   end

   assign hub_msg_valid_o = valid_ff;
   assign hub_msg_kind_o  = kind_ff;
   assign queue_full_o    = full_ff;

endmodule
`default_nettype wire

// ===== inc/emr_pkg.sv
// package for the error message router: register map, field positions,
// reset values, message kinds and counts.
// assumes a classic wishbone slave with 32-bit data and byte addressing.
package emr_pkg;

   // register word indices (64h, 66h, 67h are not all word aligned,
   // so each is an index and the byte address is four times it)
   localparam logic [7:0] SERR_EN_IDX     = 8'h64;
   localparam logic [7:0] SMI_EN_IDX      = 8'h66;
   localparam logic [7:0] SCI_EN_IDX      = 8'h67;
   localparam logic [7:0] FLAG_STS_IDX    = 8'h68;
   localparam logic [7:0] GLOBAL_CTL_IDX  = 8'h69;
   localparam logic [7:0] MSG_CNT_IDX     = 8'h6a;

   // reset values
   localparam logic [15:0] SERR_EN_RST    = 16'h0000;
   localparam logic [7:0]  SMI_EN_RST     = 8'h00;
   localparam logic [7:0]  SCI_EN_RST     = 8'h00;
   localparam logic [15:0] FLAG_STS_RST   = 16'h0000;
   localparam logic        SERR_GLB_RST   = 1'b0;

   // writable bits of each enable register (reserved bits read zero)
   localparam logic [15:0] SERR_EN_MASK   = 16'h2be3;
   localparam logic [7:0]  SMI_EN_MASK    = 8'h0b;
   localparam logic [7:0]  SCI_EN_MASK    = 8'h0b;

   // error flag and enable bit positions
   localparam int FSB_GLITCH_BIT  = 13;
   localparam int THERMAL_BIT     = 11;
   localparam int LOCK_BIT        = 9;
   localparam int REFRESH_BIT     = 8;
   localparam int THROTTLE_BIT    = 7;
   localparam int TABORT_BIT      = 6;
   localparam int UNSC_BIT        = 5;
   localparam int THERM_SMI_BIT   = 3;
   localparam int THERM_SCI_BIT   = 3;
   localparam logic [15:0] FLAG_MASK = 16'h2be0;

   // queued refresh count that raises the refresh timeout
   localparam int          REFRESH_LIMIT  = 1024;
   localparam int          REFQ_W         = 11;

   // pending message queue
   localparam int          MSGQ_DEPTH     = 16;
   localparam int          MSGQ_AW        = 4;

   // message kind on the hub link
   localparam logic [1:0]  MSG_SERR       = 2'h1;
   localparam logic [1:0]  MSG_SMI        = 2'h2;
   localparam logic [1:0]  MSG_SCI        = 2'h3;

   typedef enum logic [1:0] {
      EMR_IDLE,
      EMR_LOAD,
      EMR_SEND
   } emr_state_t;

endpackage
